// file: logic/vwc_top.sv
// window two crop, line drop and frame decimation control
//
// What this block does
// R01: report qualifier delay after horizontal reference trailing edge, read only
// R02: host sets first active line at least 7 (625) or 10 (525)
// R03: input count spans active lines; first plus count clipped to line total
// R04: decimation on outputs programmed frames per 3000; off outputs all
// R05: field gate 11 off, 10 odd only, 01 even only, 00 both
// R06: host keeps output line count not above input line count
// R07: fewer output lines than input lines drops input lines
// R08: window starts at horizontal begin in scaled pixels, cropping left
// R09: window length in scaled pixels equals horizontal length field
// R10: host keeps begin plus length within scaled line pixels
// R11: host sets scaled line pixels even, 32 to 864
// R12: host writes zero to reserved bits
// R13: dropped lines spread evenly over the field
`timescale 1ns/1ps
`default_nettype none
`include "vwc_params.svh"
module vwc_top (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// register port
	input wire logic [8:0] ADDR,
	input wire logic [11:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [11:0] RDATA,
	// video timing in
	input wire logic HORIZONTAL_REFERENCE,
	input wire logic VREF,
	input wire logic FIELD_ODD,
	input wire logic PIX_EN,
	input wire logic ACT_IN,
	// window out
	output logic WIN_ACT,
	output logic WIN_LINE
);
	// ********************************
	// registers
	// ********************************
	logic [11:0] vbeg, vlin, vlout, hbeg, hlen, npix, tdecn, stdsel;
	logic [11:0] next_vbeg, next_vlin, next_vlout, next_hbeg;
	logic [11:0] next_hlen, next_npix, next_tdecn, next_stdsel;
	logic [11:0] qdelay, next_qdelay;
	logic [11:0] next_rdata;

	always_comb begin
		next_vbeg = vbeg;
		next_vlin = vlin;
		next_vlout = vlout;
		next_hbeg = hbeg;
		next_hlen = hlen;
		next_npix = npix;
		next_tdecn = tdecn;
		next_stdsel = stdsel;
		next_rdata = 12'h000;
		if (WR) begin
			case (ADDR)
				`VWC_ADDR_VBEG: next_vbeg = WDATA;
				`VWC_ADDR_VLIN: next_vlin = WDATA;
				`VWC_ADDR_VLOUT: next_vlout = WDATA;
				`VWC_ADDR_HBEG: next_hbeg = WDATA;
				`VWC_ADDR_HLEN: next_hlen = WDATA;
				`VWC_ADDR_NPIX: next_npix = WDATA;
				`VWC_ADDR_TDECN: next_tdecn = WDATA;
				`VWC_ADDR_STDSEL: next_stdsel = WDATA;
				default: next_vbeg = vbeg;
			endcase
		end
		if (RD) begin
			case (ADDR)
				// R01 delay readback
				`VWC_ADDR_QDELAY: next_rdata = qdelay;
				`VWC_ADDR_VBEG: next_rdata = vbeg;
				`VWC_ADDR_VLIN: next_rdata = vlin;
				`VWC_ADDR_VLOUT: next_rdata = vlout;
				`VWC_ADDR_HBEG: next_rdata = hbeg;
				`VWC_ADDR_HLEN: next_rdata = hlen;
				`VWC_ADDR_NPIX: next_rdata = npix;
				`VWC_ADDR_TDECN: next_rdata = tdecn;
				`VWC_ADDR_STDSEL: next_rdata = stdsel;
				default: next_rdata = 12'h000;
			endcase
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			vbeg <= `VWC_RST_VBEG;
			vlin <= `VWC_RST_VLIN;
			vlout <= `VWC_RST_VLOUT;
			hbeg <= `VWC_RST_HBEG;
			hlen <= `VWC_RST_HLEN;
			npix <= `VWC_RST_NPIX;
			tdecn <= `VWC_RST_TDECN;
			stdsel <= `VWC_RST_STDSEL;
			RDATA <= 12'h000;
		end else begin
			vbeg <= next_vbeg;
			vlin <= next_vlin;
			vlout <= next_vlout;
			hbeg <= next_hbeg;
			hlen <= next_hlen;
			npix <= next_npix;
			tdecn <= next_tdecn;
			stdsel <= next_stdsel;
			RDATA <= next_rdata;
		end
	end

	// ********************************
	// edges and qualifier delay
	// ********************************
	logic horizontal_reference_d, vref_d, act_d;
	logic [10:0] dcnt, next_dcnt;
	logic dmeas, next_dmeas;
	logic horizontal_reference_fall, vref_rise, act_rise;

	assign horizontal_reference_fall = horizontal_reference_d & ~HORIZONTAL_REFERENCE;
	assign vref_rise = VREF & ~vref_d;
	assign act_rise = ACT_IN & ~act_d;

	always_comb begin
		next_dcnt = dcnt;
		next_dmeas = dmeas;
		next_qdelay = qdelay;
		// R01 measure delay
		if (horizontal_reference_fall) begin
			next_dcnt = 11'h000;
			next_dmeas = 1'b1;
		end else if (dmeas) begin
			if (act_rise) begin
				next_qdelay = {dcnt, 1'b0};
				next_dmeas = 1'b0;
			end else if (dcnt != 11'h7ff) begin
				next_dcnt = dcnt + 11'h001;
			end
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			horizontal_reference_d <= 1'b0;
			vref_d <= 1'b0;
			act_d <= 1'b0;
			dcnt <= 11'h000;
			dmeas <= 1'b0;
			qdelay <= 12'h000;
		end else begin
			horizontal_reference_d <= HORIZONTAL_REFERENCE;
			vref_d <= VREF;
			act_d <= ACT_IN;
			dcnt <= next_dcnt;
			dmeas <= next_dmeas;
			qdelay <= next_qdelay;
		end
	end

	// ********************************
	// vertical window and decimation
	// ********************************
	vwc_line_if lp ();
	vwc_line_sel u_sel (
		.clock(CLOCK),
		.rst(RST),
		.lp(lp)
	);

	vwc_pkg::vwc_vstate_t vst, next_vst;
	logic [9:0] line, next_line;
	logic [9:0] vend;
	logic [9:0] ltot;
	logic [11:0] fcnt, next_fcnt;
	logic [11:0] fsent, next_fsent;
	logic fgate, frame_ok, next_frame_ok, line_on, next_line_on;
	logic [1:0] fdis;
	logic [9:0] raw_end;

	// R03 clip to standard
	always_comb begin
		ltot = stdsel[0] ? `VWC_LINES_525 : `VWC_LINES_625;
		raw_end = {1'b0, vbeg[8:0]} + {1'b0, vlin[8:0]};
		vend = (raw_end > ltot) ? ltot : raw_end;
	end

	// R05 field gate
	always_comb begin
		fdis = vlin[`VWC_BIT_FDIS_HI:`VWC_BIT_FDIS_LO];
		case (fdis)
			2'b11: fgate = 1'b0;
			2'b10: fgate = FIELD_ODD;
			2'b01: fgate = ~FIELD_ODD;
			default: fgate = 1'b1;
		endcase
	end

	assign lp.field_start = vref_rise;
	assign lp.line_step = horizontal_reference_fall && vst == vwc_pkg::VWC_ACTIVE;
	assign lp.in_lines = vlin[8:0];
	assign lp.out_lines = vlout[8:0];

	always_comb begin
		next_vst = vst;
		next_line = line;
		next_fcnt = fcnt;
		next_fsent = fsent;
		next_frame_ok = frame_ok;
		next_line_on = line_on;
		if (vref_rise) begin
			next_line = 10'h000;
			next_vst = vwc_pkg::VWC_IDLE;
			next_line_on = 1'b0;
			// R04 frame decimation, counted on odd field start
			if (FIELD_ODD) begin
				if (fcnt == `VWC_TDEC_INTERVAL - 12'h001) begin
					next_fcnt = 12'h000;
					next_fsent = 12'h000;
				end else begin
					next_fcnt = fcnt + 12'h001;
				end
				if (!vlin[`VWC_BIT_TDEC]) begin
					next_frame_ok = 1'b1;
				end else begin
					next_frame_ok = (next_fsent < tdecn);
					if (next_frame_ok) begin
						next_fsent = next_fsent + 12'h001;
					end
				end
			end
		end else if (horizontal_reference_fall) begin
			next_line = line + 10'h001;
			next_line_on = 1'b0;
			case (vst)
				vwc_pkg::VWC_IDLE: begin
					if (next_line == {1'b0, vbeg[8:0]}) begin
						next_vst = vwc_pkg::VWC_ACTIVE;
					end
				end
				vwc_pkg::VWC_ACTIVE: begin
					if (next_line >= vend) begin
						next_vst = vwc_pkg::VWC_DONE;
					end
				end
				default: next_vst = vst;
			endcase
			// R07 keep or drop line
			next_line_on = (next_vst == vwc_pkg::VWC_ACTIVE) &&
				(vst == vwc_pkg::VWC_IDLE || lp.keep);
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			vst <= vwc_pkg::VWC_IDLE;
			line <= 10'h000;
			fcnt <= 12'h000;
			fsent <= 12'h000;
			frame_ok <= 1'b1;
			line_on <= 1'b0;
		end else begin
			vst <= next_vst;
			line <= next_line;
			fcnt <= next_fcnt;
			fsent <= next_fsent;
			frame_ok <= next_frame_ok;
			line_on <= next_line_on;
		end
	end

	// ********************************
	// horizontal crop
	// ********************************
	logic [10:0] pix, next_pix;
	logic next_win_act;
	logic [11:0] hend;

	always_comb begin
		hend = {1'b0, hbeg[10:0]} + {1'b0, hlen[10:0]};
		next_pix = pix;
		if (horizontal_reference_fall || !ACT_IN) begin
			next_pix = 11'h000;
		end else if (PIX_EN && pix != 11'h7ff) begin
			next_pix = pix + 11'h001;
		end
		// R08 left crop, R09 length
		next_win_act = ACT_IN && PIX_EN && line_on && frame_ok && fgate &&
			({1'b0, pix} >= {1'b0, hbeg[10:0]}) && ({1'b0, pix} < hend) &&
			(pix < npix[10:0]);
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			pix <= 11'h000;
			WIN_ACT <= 1'b0;
			WIN_LINE <= 1'b0;
		end else begin
			pix <= next_pix;
			WIN_ACT <= next_win_act;
			WIN_LINE <= line_on && frame_ok && fgate;
		end
	end
endmodule : vwc_top
`default_nettype wire

// file: logic/vwc_params.svh
// register offsets, field positions, reset values and limits for window two
`ifndef VWC_PARAMS_SVH
`define VWC_PARAMS_SVH

`define VWC_ADDR_QDELAY 9'h11f
`define VWC_ADDR_VBEG 9'h12a
`define VWC_ADDR_VLIN 9'h12b
`define VWC_ADDR_VLOUT 9'h12c
`define VWC_ADDR_HBEG 9'h12d
`define VWC_ADDR_HLEN 9'h12e
`define VWC_ADDR_NPIX 9'h12f
`define VWC_ADDR_TDECN 9'h157
`define VWC_ADDR_STDSEL 9'h158

`define VWC_RST_VBEG 12'h011
`define VWC_RST_VLIN 12'h1f4
`define VWC_RST_VLOUT 12'h0f0
`define VWC_RST_HBEG 12'h000
`define VWC_RST_HLEN 12'h280
`define VWC_RST_NPIX 12'h280
`define VWC_RST_TDECN 12'h000
`define VWC_RST_STDSEL 12'h000

`define VWC_BIT_TDEC 9
`define VWC_BIT_FDIS_HI 11
`define VWC_BIT_FDIS_LO 10

`define VWC_TDEC_INTERVAL 12'hbb8
`define VWC_LINES_625 10'h139
`define VWC_LINES_525 10'h107

`endif

// file: logic/vwc_pkg.sv
// types shared by the window two logic
package vwc_pkg;
	typedef enum logic [1:0] {
		VWC_IDLE,
		VWC_ACTIVE,
		VWC_DONE
	} vwc_vstate_t;
endpackage : vwc_pkg

// file: logic/vwc_line_if.sv
// line compression step exchanged between the top and the line selector
`timescale 1ns/1ps
`default_nettype none
interface vwc_line_if;
	logic field_start;
	logic line_step;
	logic [8:0] in_lines;
	logic [8:0] out_lines;
	logic keep;
	modport ctrl (output field_start, output line_step, output in_lines,
		output out_lines, input keep);
	modport sel (input field_start, input line_step, input in_lines,
		input out_lines, output keep);
endinterface : vwc_line_if
`default_nettype wire

// file: logic/vwc_line_sel.sv
// even line dropping by a bresenham accumulator
`timescale 1ns/1ps
`default_nettype none
module vwc_line_sel (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// step port
	vwc_line_if.sel lp
);
	logic [9:0] acc;
	logic [9:0] next_acc;
	logic [9:0] sum;

	// R13 even spreading
	always_comb begin
		sum = acc + {1'b0, lp.out_lines};
		lp.keep = sum >= {1'b0, lp.in_lines};
		next_acc = acc;
		if (lp.field_start) begin
			next_acc = 10'h000;
		end else if (lp.line_step) begin
			// R07 drop lines
			next_acc = lp.keep ? sum - {1'b0, lp.in_lines} : sum;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			acc <= 10'h000;
		end else begin
			acc <= next_acc;
		end
	end
endmodule : vwc_line_sel
`default_nettype wire

// file: verification/vwc_pix_sink.sv
// pixel sink counting window pixels
`timescale 1ns/1ps
`default_nettype none
module vwc_pix_sink (
	// window out
	input wire logic clock,
	input wire logic win_act,
	// count
	output logic [11:0] pix
);
	initial pix = 12'h000;
	always @(posedge clock)
		if (win_act === 1'b1)
			pix <= pix + 12'h001;
endmodule : vwc_pix_sink
`default_nettype wire

// file: verification/vwc_top_asserts.sv
// window two checker
`timescale 1ns/1ps
`default_nettype none
module vwc_top_asserts (
	// bus
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [8:0] ADDR,
	input wire logic [11:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [11:0] RDATA,
	// video
	input wire logic HORIZONTAL_REFERENCE,
	input wire logic VREF,
	input wire logic FIELD_ODD,
	input wire logic PIX_EN,
	input wire logic ACT_IN,
	input wire logic WIN_ACT
);
	logic [1:0] gate;
	logic [10:0] hlen;
	logic odd;
	logic [11:0] cnt;
	// shadows of gate and length, field parity, pixels per line
	always_ff @(posedge CLOCK or posedge RST)
		if (RST) begin
			gate <= 2'h0;
			hlen <= 11'h280;
			odd <= 1'b0;
			cnt <= 12'h000;
		end else begin
			if (WR && ADDR == 9'h12b)
				gate <= WDATA[11:10];
			if (WR && ADDR == 9'h12e)
				hlen <= WDATA[10:0];
			if ($rose(VREF))
				odd <= FIELD_ODD;
			cnt <= $fell(HORIZONTAL_REFERENCE) ? 12'h000 : cnt + 12'(WIN_ACT);
		end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);
	AST_RD_SLOT: assert property (RDATA != 12'h000 |-> $past(RD))
		else $error("data outside read slot");
	AST_QDELAY: assert property ($past(RD) && $past(ADDR) == 9'h11f
		|-> !RDATA[0]) else $error("delay bit zero set");
	AST_READBACK: assert property (WR && ADDR inside {[9'h12a:9'h12f]}
		##1 RD && ADDR == $past(ADDR) |=> RDATA == $past(WDATA, 2))
		else $error("readback differs");
	AST_GATE_OFF: assert property (gate == 2'h3 |-> !WIN_ACT)
		else $error("window on while disabled");
	AST_ODD_ONLY: assert property (gate == 2'h2 && !odd |-> !WIN_ACT)
		else $error("even field not gated");
	AST_EVEN_ONLY: assert property (gate == 2'h1 && odd |-> !WIN_ACT)
		else $error("odd field not gated");
	AST_ACT_CAUSE: assert property (WIN_ACT |-> $past(PIX_EN) &&
		$past(ACT_IN)) else $error("window pixel without input pixel");
	AST_HLEN_MAX: assert property (cnt <= {1'b0, hlen})
		else $error("line longer than length");
	cover property (gate == 2'h2 && odd && WIN_ACT);
	cover property ($past(RD) && $past(ADDR) == 9'h11f);
	cover property (cnt == {1'b0, hlen});
endmodule : vwc_top_asserts
bind vwc_top vwc_top_asserts CHK (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .HORIZONTAL_REFERENCE(HORIZONTAL_REFERENCE),
	.VREF(VREF), .FIELD_ODD(FIELD_ODD), .PIX_EN(PIX_EN),
	.ACT_IN(ACT_IN), .WIN_ACT(WIN_ACT));
`default_nettype wire

// file: verification/vwc_top_tb.sv
// window two bench
`timescale 1ns/1ps
`default_nettype none
module vwc_top_tb;
	logic CLOCK = 1'b0;
	logic RST = 1'b1;
	logic [8:0] ADDR = 9'h000;
	logic [11:0] WDATA = 12'h000;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic HORIZONTAL_REFERENCE = 1'b0;
	logic VREF = 1'b0;
	logic FIELD_ODD = 1'b0;
	logic PIX_EN = 1'b0;
	logic ACT_IN = 1'b0;
	logic [11:0] RDATA, pix, nl, np, nw;
	logic WIN_ACT, WIN_LINE;
	int n_fail = 0;
	int total_checks = 0;
	vwc_top DUT (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .HORIZONTAL_REFERENCE(HORIZONTAL_REFERENCE), .VREF(VREF),
		.FIELD_ODD(FIELD_ODD), .PIX_EN(PIX_EN), .ACT_IN(ACT_IN),
		.WIN_ACT(WIN_ACT), .WIN_LINE(WIN_LINE));
	vwc_pix_sink SINK (.clock(CLOCK), .win_act(WIN_ACT), .pix(pix));
	initial forever #2.5 CLOCK = ~CLOCK;
	task chk(input logic [11:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [8:0] a, input logic [11:0] d);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLOCK);
		WR <= 1'b0;
		@(posedge CLOCK);
	endtask : wr
	task rd(input logic [8:0] a, input logic [11:0] e);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLOCK);
		RD <= 1'b0;
		#1;
		chk(RDATA, e);
		@(posedge CLOCK);
	endtask : rd
	// qualifier rises three cycles after the reference falls
	task line;
		HORIZONTAL_REFERENCE <= 1'b1;
		repeat (4) @(posedge CLOCK);
		HORIZONTAL_REFERENCE <= 1'b0;
		repeat (3) @(posedge CLOCK);
		ACT_IN <= 1'b1;
		PIX_EN <= 1'b1;
		repeat (32) @(posedge CLOCK);
		ACT_IN <= 1'b0;
		PIX_EN <= 1'b0;
		repeat (2) @(posedge CLOCK);
	endtask : line
	task fld(input logic odd, input int n);
		logic [11:0] k;
		nl = 12'h000;
		nw = 12'h000;
		np = pix;
		VREF <= 1'b1;
		FIELD_ODD <= odd;
		repeat (2) @(posedge CLOCK);
		VREF <= 1'b0;
		repeat (n) begin
			k = pix;
			line();
			nl = nl + 12'(pix != k);
			// line flag still stands for the line just ended
			nw = nw + 12'(WIN_LINE === 1'b1);
		end
		np = pix - np;
	endtask : fld
	task t_regs;
		logic [11:0] rv [6] = '{12'h011, 12'h1f4, 12'h0f0, 12'h000,
			12'h280, 12'h280};
		for (int i = 0; i < 6; i++)
			rd(9'h12a + 9'(i), rv[i]);
		wr(9'h100, 12'h007);
		rd(9'h100, 12'h000);
		ADDR <= 9'h12d;
		WDATA <= 12'h005;
		WR <= 1'b1;
		@(posedge CLOCK);
		WR <= 1'b0;
		rd(9'h12d, 12'h005);
	endtask : t_regs
	task t_horiz;
		wr(9'h12d, 12'h000);
		wr(9'h12f, 12'h020);
		wr(9'h12e, 12'h020);
		wr(9'h12b, 12'h008);
		wr(9'h12c, 12'h008);
		wr(9'h12a, 12'h007);
		fld(1'b1, 16);
		chk(nl, 12'h008);
		chk(nw, 12'h008);
		chk(np, 12'h100);
		rd(9'h11f, 12'h004);
		wr(9'h12d, 12'h016);
		wr(9'h12e, 12'h00a);
		fld(1'b1, 16);
		chk(np, 12'h050);
	endtask : t_horiz
	task t_drop;
		wr(9'h12c, 12'h004);
		fld(1'b0, 16);
		chk(nl, 12'h004);
		chk(nw, 12'h004);
		chk(np, 12'h028);
		wr(9'h12c, 12'h008);
	endtask : t_drop
	task t_gate;
		logic [1:0] g;
		logic f;
		for (int i = 0; i < 8; i++) begin
			g = 2'(i >> 1);
			f = i[0];
			wr(9'h12b, {g, 10'h008});
			fld(f, 16);
			chk(nl, (f ? !g[0] : !g[1]) ? 12'h008 : 12'h000);
			chk(nw, (f ? !g[0] : !g[1]) ? 12'h008 : 12'h000);
		end
	endtask : t_gate
	task t_dec;
		wr(9'h157, 12'h000);
		wr(9'h12b, 12'h208);
		fld(1'b1, 16);
		chk(nl, 12'h000);
		// one frame allowed: the next frame passes, the one after is held
		wr(9'h157, 12'h001);
		fld(1'b1, 16);
		chk(nl, 12'h008);
		fld(1'b1, 16);
		chk(nl, 12'h000);
		wr(9'h12b, 12'h008);
	endtask : t_dec
	// 525 standard: lines 260 to 262 only
	task t_clip;
		wr(9'h158, 12'h001);
		wr(9'h12a, 12'h104);
		wr(9'h12b, 12'h00a);
		wr(9'h12c, 12'h00a);
		fld(1'b1, 264);
		chk(nl, 12'h003);
	endtask : t_clip
	task results;
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results
	initial begin
		repeat (5) @(posedge CLOCK);
		RST <= 1'b0;
		t_regs();
		t_horiz();
		t_drop();
		t_gate();
		t_dec();
		t_clip();
		results();
	end
endmodule : vwc_top_tb
`default_nettype wire
